// >>> rtl/mlg_pkg.sv
/*
 * mlg_pkg: constants, register map and types of the motion limit guard.
 * Assumes a 200 MHz control clock; velocities in um/s, rates in mm/s^2.
 */
package mlg_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int  CLK_MHZ        = 200;
    localparam real SAMPLE_MS_STD  = 0.5333;
    localparam real SAMPLE_MS_COE  = 0.5;
    localparam int  SAMPLE_CYC_STD = $rtoi(SAMPLE_MS_STD * 1000.0 * CLK_MHZ);
    localparam int  SAMPLE_CYC_COE = $rtoi(SAMPLE_MS_COE * 1000.0 * CLK_MHZ);
    // rate per sample in um/s = rate * scale >> shift (sample period in ms)
    localparam logic [10:0] ACC_SCALE_STD = 11'h222;
    localparam logic [10:0] ACC_SCALE_COE = 11'h200;
    localparam int          ACC_SHIFT     = 10;

    // ------------------------------------------------------------
    // register map (word index)
    // ------------------------------------------------------------
    localparam int          AW        = 5;
    localparam logic [4:0]  A_MODE    = 5'h00;
    localparam logic [4:0]  A_CMD     = 5'h01;
    localparam logic [4:0]  A_VLIM    = 5'h02;
    localparam logic [4:0]  A_BSPD    = 5'h0B;
    localparam logic [4:0]  A_STATUS  = 5'h0C;
    localparam logic [4:0]  A_IRQ_ST  = 5'h0D;
    localparam logic [4:0]  A_IRQ_EN  = 5'h0E;
    localparam logic [4:0]  A_IRQ_CLR = 5'h0F;
    localparam logic [4:0]  A_VOUT    = 5'h10;
    localparam int          CFG_N     = 10;
    localparam int I_VLIM = 0, I_ACC = 1, I_DEC = 2, I_EDEC = 3, I_SMOOTH = 4;
    localparam int I_PWIN = 5, I_PWARN = 6, I_VWARN = 7, I_BDLY = 8, I_BSPD = 9;
    localparam logic [31:0] CFG_RST [CFG_N] = '{
        32'h0001_86A0, 32'h0000_4E20, 32'h0000_4E20, 32'h0000_9C40, 32'h0000_0064,
        32'h0000_1388, 32'h0000_09C4, 32'h0BEB_C200, 32'h0000_00C8, 32'h0000_03E8};
    localparam logic [8:0]  SMOOTH_MAX = 9'h1F4;
    localparam int CMD_EN = 0, CMD_DIS = 1, CMD_CLR = 2;

    // ------------------------------------------------------------
    // events and types
    // ------------------------------------------------------------
    localparam int NEV = 4;
    localparam int EV_FAULT = 0, EV_WARN = 1, EV_ESTOP = 2, EV_BRAKE = 3;

    typedef enum logic [1:0] {
        MODE_POS   = 2'h0,
        MODE_VEL   = 2'h1,
        MODE_FORCE = 2'h2,
        MODE_ALONE = 2'h3
    } mlg_mode_t;

    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_RUN  = 4'h2,
        ST_STOP = 4'h4,
        ST_DIS  = 4'h8
    } mlg_state_t;

endpackage

// >>> rtl/mlg_mavg.sv
/*
 * mlg_mavg: moving average over the last depth samples, serial divide.
 * Assumes samples far apart (> 42 clocks) and restart on any depth change.
 */
`timescale 1ns/1ps
module mlg_mavg
    import mlg_pkg::*;
#(
    parameter int W    = 32,
    parameter int DMAX = 500
)(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // samples
    input  wire logic                tick,
    input  wire logic                restart,
    input  wire logic [8:0]          depth,
    input  wire logic signed [W-1:0] din,
    // average
    output logic signed [W-1:0]      dout,
    output logic                     dvalid
);
    localparam int SW = W + 10;

    logic signed [W-1:0]  mem [0:DMAX-1];
    logic signed [W-1:0]  oldest;
    logic [8:0]           idx_q, idx_d, fill_q, fill_d;
    logic signed [SW-1:0] sum_q, sum_d;
    logic [SW-1:0]        quo_q, quo_d, qf;
    logic [9:0]           rem_q, rem_d;
    logic [10:0]          sh;
    logic [5:0]           cnt_q, cnt_d;
    logic                 busy_q, busy_d, neg_q, neg_d, ge;
    logic signed [W-1:0]  dout_d;
    logic                 dvalid_d;

    // ------------------------------------------------------------
    // window sum and divide by samples held
    // ------------------------------------------------------------
    always_comb
    begin
        idx_d = idx_q; fill_d = fill_q; sum_d = sum_q; quo_d = quo_q;
        rem_d = rem_q; cnt_d = cnt_q; busy_d = busy_q; neg_d = neg_q;
        dout_d = dout; dvalid_d = 1'b0;
        // partly filled window averages what it holds, so no jump at start
        oldest = (fill_q == depth) ? mem[idx_q] : '0;
        sh = {rem_q, quo_q[SW-1]};
        ge = sh >= {2'h0, fill_q};
        qf = {quo_q[SW-2:0], ge};
        if (restart)
        begin
            idx_d = '0; fill_d = '0; sum_d = '0; busy_d = 1'b0;
        end
        else if (tick)
        begin
            sum_d  = sum_q + SW'(din) - SW'(oldest);
            idx_d  = (idx_q + 9'h001 >= depth) ? 9'h000 : idx_q + 9'h001;
            fill_d = (fill_q < depth) ? fill_q + 9'h001 : fill_q;
            neg_d  = sum_d[SW-1];
            quo_d  = neg_d ? SW'(-sum_d) : SW'(sum_d);
            rem_d  = '0;
            cnt_d  = 6'(SW);
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            rem_d = ge ? 10'(sh - {2'h0, fill_q}) : sh[9:0];
            quo_d = qf;
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01)
            begin
                busy_d   = 1'b0;
                dvalid_d = 1'b1;
                dout_d   = neg_q ? -$signed(qf[W-1:0]) : $signed(qf[W-1:0]);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (tick && !restart)
            mem[idx_q] <= din;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idx_q <= '0; fill_q <= '0; sum_q <= '0; quo_q <= '0; rem_q <= '0;
            cnt_q <= '0; busy_q <= 1'b0; neg_q <= 1'b0; dout <= '0; dvalid <= 1'b0;
        end
        else
        begin
            idx_q <= idx_d; fill_q <= fill_d; sum_q <= sum_d; quo_q <= quo_d;
            rem_q <= rem_d; cnt_q <= cnt_d; busy_q <= busy_d; neg_q <= neg_d;
            dout <= dout_d; dvalid <= dvalid_d;
        end
    end

    chk_div_done: assert property (@(posedge clk) disable iff (rst)
        busy_q && cnt_q == 6'h01 && !restart && !tick |=> dvalid)
        else $error("average not delivered after divide");
    chk_fill_cap: assert property (@(posedge clk) disable iff (rst)
        tick && !restart && fill_q == depth |=> fill_q == $past(depth))
        else $error("window grew past depth");
endmodule

// >>> rtl/mlg_motion_guard.sv
/*
 * mlg_motion_guard: clamps commanded velocity and rates, emergency stop,
 * smoothing, error windows, brake and interrupt.
 * Assumes command, event and error inputs come from logic on clk.
 */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mlg_motion_guard
    import mlg_pkg::*;
#(
    parameter bit COE_VARIANT = 1'b0,
    parameter int SAMPLE_CYC  = COE_VARIANT ? SAMPLE_CYC_COE : SAMPLE_CYC_STD
)(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register port
    input  wire logic [AW-1:0]      reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // host command and events
    input  wire logic signed [31:0] cmd_vel,
    input  wire logic               dis_in,
    input  wire logic               stop_move,
    input  wire logic               home_found,
    input  wire logic               jog_stop,
    // feedback errors
    input  wire logic signed [31:0] pos_err,
    input  wire logic signed [31:0] vel_err,
    // drive outputs
    output logic signed [31:0]      vel_out,
    output logic                    motor_en,
    output logic                    brake_out,
    output logic                    fault,
    output logic                    warning,
    output logic                    irq
);
    localparam int DIVW = $clog2(SAMPLE_CYC + 1);
    localparam logic [10:0] SCALE = COE_VARIANT ? ACC_SCALE_COE : ACC_SCALE_STD;

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    function automatic logic [31:0] step_of(input logic [31:0] r);
        logic [42:0] p;
        p = r * SCALE;
        return p[ACC_SHIFT +: 32];
    endfunction

    // ------------------------------------------------------------
    // sample tick
    // ------------------------------------------------------------
    logic [DIVW-1:0] div_q, div_d;
    logic            tick;

    always_comb
    begin
        tick  = div_q == DIVW'(SAMPLE_CYC - 1);
        div_d = tick ? '0 : div_q + 1'b1;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    mlg_mode_t         mode_q, mode_d;
    logic [31:0]       cfg_q [CFG_N];
    logic [31:0]       cfg_d [CFG_N];
    logic              edset_q, edset_d;
    logic [NEV-1:0]    ist_q, ist_d, ien_q, ien_d, ev;
    logic [31:0]       rdata_d, edec, status;
    logic              en_cmd, dis_cmd, clr_cmd, cfg_hit, smooth_wr;
    logic [3:0]        cfg_i;
    mlg_state_t        st_q, st_d;
    logic signed [31:0] vel_d;
    logic              fault_d, warn_d;

    always_comb
    begin
        cfg_hit   = reg_addr >= A_VLIM && reg_addr <= A_BSPD;
        cfg_i     = 4'(reg_addr - A_VLIM);
        en_cmd    = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_EN];
        dis_cmd   = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_DIS];
        clr_cmd   = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CLR];
        smooth_wr = reg_wr && cfg_hit && int'(cfg_i) == I_SMOOTH;
        // unwritten emergency rate tracks the accel limit
        edec = edset_q ? cfg_q[I_EDEC] : {cfg_q[I_ACC][30:0], 1'b0};
        status = {24'h0, st_q, brake_out, motor_en, warning, fault};
        mode_d = mode_q; cfg_d = cfg_q; edset_d = edset_q; ien_d = ien_q;
        if (reg_wr && reg_addr == A_MODE)
            mode_d = mlg_mode_t'(reg_wdata[1:0]);
        if (reg_wr && cfg_hit)
            cfg_d[cfg_i] = reg_wdata;
        if (smooth_wr && reg_wdata > 32'(SMOOTH_MAX))
            cfg_d[I_SMOOTH] = 32'(SMOOTH_MAX);
        if (reg_wr && cfg_hit && int'(cfg_i) == I_EDEC)
            edset_d = 1'b1;
        if (reg_wr && reg_addr == A_IRQ_EN)
            ien_d = reg_wdata[NEV-1:0];
        // set wins over a clear in the same cycle
        ist_d = ev | (ist_q & ~((reg_wr && reg_addr == A_IRQ_CLR) ? reg_wdata[NEV-1:0] : '0));
        rdata_d = '0;
        if (reg_rd)
        begin
            if (cfg_hit)
                rdata_d = (int'(cfg_i) == I_EDEC) ? edec : cfg_q[cfg_i];
            else
                case (reg_addr)
                    A_MODE:   rdata_d = {30'h0, mode_q};
                    A_STATUS: rdata_d = status;
                    A_IRQ_ST: rdata_d = 32'(ist_q);
                    A_IRQ_EN: rdata_d = 32'(ien_q);
                    A_VOUT:   rdata_d = vel_out;
                    default:  rdata_d = '0;
                endcase
        end
    end

    // ------------------------------------------------------------
    // limiting, ramp and stop sequence
    // ------------------------------------------------------------
    logic signed [31:0] ramp_q, ramp_d, ramp_nx, tgt, f_out;
    logic signed [32:0] c33, lim, diff, stp;
    logic [31:0]        bcnt_q, bcnt_d, step;
    logic               limits_on, ramp_on, filt_on, away, restart, f_valid;
    logic               dis_any, stop_any, pos_bad, warn_now;
    logic [8:0]         depth;

    always_comb
    begin
        limits_on = !(mode_q == MODE_POS && cfg_q[I_SMOOTH] == 32'h0);
        ramp_on   = limits_on && mode_q != MODE_FORCE;
        filt_on   = ramp_on && st_q == ST_RUN;
        depth     = (cfg_q[I_SMOOTH] == 32'h0) ? 9'h001 : cfg_q[I_SMOOTH][8:0];
        c33 = 33'(cmd_vel);
        lim = $signed({1'b0, cfg_q[I_VLIM]});
        tgt = cmd_vel;
        if (st_q != ST_RUN)
            tgt = '0;
        else if (limits_on && c33 > lim)
            tgt = lim[31:0];
        else if (limits_on && c33 < -lim)
            tgt = 32'(-lim);
        away = (tgt > ramp_q && ramp_q >= 0) || (tgt < ramp_q && ramp_q <= 0);
        if (st_q != ST_RUN)
            step = step_of(edec);
        else
            step = away ? step_of(cfg_q[I_ACC]) : step_of(cfg_q[I_DEC]);
        stp  = $signed({1'b0, step});
        diff = 33'(tgt) - 33'(ramp_q);
        if (!ramp_on)
            ramp_nx = tgt;
        else if (diff > stp)
            ramp_nx = 32'(33'(ramp_q) + stp);
        else if (diff < -stp)
            ramp_nx = 32'(33'(ramp_q) - stp);
        else
            ramp_nx = tgt;
        pos_bad  = mag(pos_err) > cfg_q[I_PWIN];
        warn_now = mag(pos_err) > cfg_q[I_PWARN] || mag(vel_err) > cfg_q[I_VWARN];
        dis_any  = dis_cmd || dis_in || fault_d;
        stop_any = stop_move || home_found || jog_stop;
    end

    always_comb
    begin
        st_d = st_q; ramp_d = ramp_q; bcnt_d = bcnt_q; restart = smooth_wr;
        case (st_q)
            ST_OFF:
            begin
                ramp_d = '0;
                if (en_cmd && !fault_d)
                begin
                    st_d = ST_RUN;
                    restart = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (dis_any)
                begin
                    st_d = ST_DIS;
                    ramp_d = vel_out;
                    bcnt_d = '0;
                end
                else if (stop_any)
                begin
                    st_d = ST_STOP;
                    ramp_d = vel_out;
                end
                else if (tick)
                    ramp_d = ramp_nx;
            end
            ST_STOP:
            begin
                if (dis_any)
                begin
                    st_d = ST_DIS;
                    bcnt_d = '0;
                end
                else if (tick)
                begin
                    ramp_d = ramp_nx;
                    if (ramp_nx == 0)
                    begin
                        st_d = ST_RUN;
                        restart = 1'b1;
                    end
                end
            end
            ST_DIS:
            begin
                if (tick)
                begin
                    ramp_d = ramp_nx;
                    bcnt_d = bcnt_q + 32'h1;
                    // brake early once slow, or when the delay runs out
                    if (bcnt_q >= cfg_q[I_BDLY] || mag(vel_out) <= cfg_q[I_BSPD])
                        st_d = ST_OFF;
                end
            end
            default: st_d = ST_OFF;
        endcase
        vel_d = vel_out;
        if (st_q == ST_OFF)
            vel_d = '0;
        else if (!filt_on)
            vel_d = ramp_d;
        else if (f_valid)
            vel_d = f_out;
        fault_d = (fault && !clr_cmd) || (tick && st_q != ST_OFF && pos_bad);
        warn_d  = tick ? warn_now : warning;
        ev = '0;
        ev[EV_FAULT] = fault_d && !fault;
        ev[EV_WARN]  = warn_d && !warning;
        ev[EV_ESTOP] = st_d != st_q && (st_d == ST_STOP || st_d == ST_DIS);
        ev[EV_BRAKE] = st_q == ST_DIS && st_d == ST_OFF;
    end

    // depth change or a finished stop starts a fresh window
    mlg_mavg #(.W(32), .DMAX(500)) u_avg (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick && filt_on),
        .restart (restart),
        .depth   (depth),
        .din     (ramp_nx),
        .dout    (f_out),
        .dvalid  (f_valid)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= '0; mode_q <= MODE_POS; cfg_q <= CFG_RST; edset_q <= 1'b0;
            ist_q <= '0; ien_q <= '0; reg_rdata <= '0; st_q <= ST_OFF;
            ramp_q <= '0; bcnt_q <= '0; vel_out <= '0; fault <= 1'b0; warning <= 1'b0;
        end
        else
        begin
            div_q <= div_d; mode_q <= mode_d; cfg_q <= cfg_d; edset_q <= edset_d;
            ist_q <= ist_d; ien_q <= ien_d; reg_rdata <= rdata_d; st_q <= st_d;
            ramp_q <= ramp_d; bcnt_q <= bcnt_d; vel_out <= vel_d; fault <= fault_d;
            warning <= warn_d;
        end
    end

    assign motor_en  = st_q != ST_OFF;
    assign brake_out = st_q == ST_OFF;
    assign irq       = |(ist_q & ien_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_fault_stop;
        fault ##0 (st_q == ST_DIS || st_q == ST_OFF);
    endsequence

    chk_force_speed: assert property (tick && st_q == ST_RUN && mode_q == MODE_FORCE
        && !dis_any && !stop_any |=> mag(ramp_q) <= $past(cfg_q[I_VLIM]))
        else $error("force mode speed not clamped");
    chk_rate_bound: assert property (tick && filt_on && !dis_any && !stop_any
        |=> mag(32'(ramp_q - $past(ramp_q))) <= $past(step))
        else $error("ramp step above rate limit");
    chk_reset_vals: assert property ($fell(rst) |-> cfg_q[I_VLIM] == 32'h0001_86A0
        && cfg_q[I_ACC] == 32'h0000_4E20 && cfg_q[I_DEC] == 32'h0000_4E20)
        else $error("limit defaults wrong");
    chk_edec_track: assert property ($changed(cfg_q[I_ACC]) && !edset_q
        |-> edec == 32'(cfg_q[I_ACC] * 2))
        else $error("emergency rate not twice accel");
    chk_bypass: assert property (tick && st_q == ST_RUN && !limits_on && !dis_any
        && !stop_any |=> vel_out == $past(cmd_vel))
        else $error("bypass does not follow command");
    chk_estop_rate: assert property (tick && st_q == ST_DIS && ramp_on
        |=> mag($past(ramp_q)) - mag(ramp_q) <= $past(step))
        else $error("emergency decel too steep");
    chk_stop_event: assert property (st_q == ST_RUN && stop_any && !dis_any
        |=> st_q == ST_STOP && motor_en)
        else $error("stop event ignored");
    chk_brake_time: assert property (tick && st_q == ST_DIS && bcnt_q >= cfg_q[I_BDLY]
        |=> brake_out && !motor_en)
        else $error("brake late after delay");
    chk_pos_fault: assert property (tick && motor_en && !fault && pos_bad
        |=> s_fault_stop ##1 (st_q != ST_RUN))
        else $error("position fault did not stop");
    chk_warn_run: assert property (tick && warn_now && st_q == ST_RUN && !dis_any
        && !stop_any && !pos_bad |=> warning && st_q == ST_RUN)
        else $error("warning missing or stopped motor");
endmodule

// >>> bench/mlg_host_model.sv
/*
 * mlg_host_model: host controller side, gives velocity command, errors, events.
 * Assumes the bench calls its tasks; every change lands just after clk rises.
 */
`timescale 1ns/1ps
module mlg_host_model
    import mlg_pkg::*;
(
    // clock
    input  wire logic          clk,
    // command and errors
    output logic signed [31:0] cmd_vel,
    output logic signed [31:0] pos_err,
    output logic signed [31:0] vel_err,
    // event pulses: disable, move stop, home found, jog stop
    output logic [3:0]         ev
);
    // ------------------------------------------------------------
    // host actions
    // ------------------------------------------------------------
    initial
    begin
        cmd_vel = '0;
        pos_err = '0;
        vel_err = '0;
        ev      = 4'h0;
    end
    // one-cycle pulse, so each request is exactly one event
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 4'h1 << k;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    task automatic set(input int v, input int pe, input int ve);
        @(posedge clk);
        cmd_vel <= v;
        pos_err <= pe;
        vel_err <= ve;
    endtask
endmodule

// >>> bench/tb_top.sv
/*
 * tb_top: self-checking bench of the motion limit guard.
 * Assumes mlg_host_model drives the host inputs; sample period cut to 64.
 */
`timescale 1ns/1ps
module tb_top
    import mlg_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int SC   = 64;
    localparam int ACC  = (20000 * int'(ACC_SCALE_STD)) >> ACC_SHIFT;
    localparam int EDEC = (40000 * int'(ACC_SCALE_STD)) >> ACC_SHIFT;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, vel_out, d;
    logic signed [31:0] cmd_vel, pos_err, vel_err;
    logic [3:0] ev;
    logic motor_en, brake_out, fault, warning, irq;
    int failures = 0, num_checks = 0;
    mlg_host_model u_host (.clk(clk), .cmd_vel(cmd_vel), .pos_err(pos_err),
        .vel_err(vel_err), .ev(ev));
    mlg_motion_guard #(.SAMPLE_CYC(SC)) u_dut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_vel(cmd_vel), .dis_in(ev[0]), .stop_move(ev[1]),
        .home_found(ev[2]), .jog_stop(ev[3]), .pos_err(pos_err), .vel_err(vel_err),
        .vel_out(vel_out), .motor_en(motor_en), .brake_out(brake_out), .fault(fault),
        .warning(warning), .irq(irq));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic ticks(input int n);
        repeat (n * SC) @(posedge clk);
        #1;
    endtask
    // bounded wait for the next change of the executed velocity
    task automatic vchg(output logic [31:0] v);
        logic [31:0] o;
        int n;
        o = vel_out;
        n = 0;
        while (vel_out === o && n < 3 * SC + 60)
        begin
            @(posedge clk);
            #1 n++;
        end
        v = vel_out;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(5'h02, d); chk("vel limit", 32'h0001_86A0, d);
        rd(5'h03, d); chk("accel limit", 32'h0000_4E20, d);
        rd(5'h04, d); chk("decel limit", 32'h0000_4E20, d);
        rd(5'h05, d); chk("emergency decel", 32'h0000_9C40, d);
        // accel limit set tenfold, as a position-mode host would
        wr(5'h03, 32'h0003_0D40);
        rd(5'h05, d); chk("edec tracks accel", 32'h0006_1A80, d);
        wr(5'h03, 32'h0000_4E20);
        rd(A_STATUS, d); chk("status", 32'h0000_0018, d);
        rd(5'h1F, d); chk("unmapped", 32'h0, d);
        wr(5'h06, 32'h0000_0258);
        rd(5'h06, d); chk("depth cap", 32'h0000_01F4, d);
        wr(5'h06, 32'h0000_0001);
    endtask
    task automatic t_force();
        wr(A_MODE, 32'h2);
        wr(A_CMD, 32'h1);
        u_host.set(50000, 0, 0);
        vchg(d); chk("force no ramp", 32'd50000, d);
        u_host.set(300000, 0, 0);
        vchg(d); chk("force speed clamp", 32'd100000, d);
        u_host.set(0, 0, 0);
        vchg(d); chk("force zero", 32'h0, d);
    endtask
    task automatic t_vel_estop();
        wr(A_MODE, 32'h1);
        u_host.set(500000, 0, 0);
        vchg(d); chk("accel step", ACC, d);
        ticks(15); chk("speed clamp", 32'd100000, vel_out);
        u_host.pulse(0);
        vchg(d); chk("disable ramp", 100000 - EDEC, d);
        rd(A_IRQ_ST, d); chk("stop event", 32'h4, d & 32'h4);
        chk("irq masked", 1'b0, irq);
        ticks(8); chk("brake", 1'b1, brake_out);
        chk("motor off", 1'b0, motor_en);
        chk("vel zero", 32'h0, vel_out);
    endtask
    task automatic t_stops();
        wr(A_CMD, 32'h1);
        for (int k = 1; k < 4; k++)
        begin
            ticks(15);
            u_host.pulse(k);
            vchg(d); chk("stop ramp", 100000 - EDEC, d);
        end
        // short brake delay runs out well before the speed gets low
        ticks(15);
        wr(5'h0A, 32'h0000_0003);
        u_host.pulse(0);
        ticks(4); chk("brake by delay", 1'b1, brake_out);
        u_host.set(0, 0, 0);
        wr(A_CMD, 32'h1);
        ticks(15);
    endtask
    task automatic t_warn();
        int pe[5] = '{2500, 2501, -2501, 0, 0};
        int ve[5] = '{0, 0, 0, 200000000, -200000001};
        logic [4:0] w = 5'h16;
        for (int i = 0; i < 5; i++)
        begin
            u_host.set(0, pe[i], ve[i]);
            ticks(2); chk("warning", w[i], warning);
            chk("no fault", 1'b0, fault);
        end
    endtask
    task automatic t_fault();
        wr(A_IRQ_EN, 32'h1);
        u_host.set(0, 5000, 0);
        ticks(2); chk("window edge", 1'b0, fault);
        u_host.set(0, 5001, 0);
        ticks(2); chk("fault", 1'b1, fault);
        chk("irq on", 1'b1, irq);
        ticks(6); chk("fault brake", 1'b1, brake_out);
        chk("fault off", 1'b0, motor_en);
        wr(A_IRQ_CLR, 32'h1);
        #1 chk("irq cleared", 1'b0, irq);
        u_host.set(0, 0, 0);
    endtask
    task automatic t_bypass();
        wr(A_CMD, 32'h4);
        wr(A_MODE, 32'h0);
        wr(5'h06, 32'h0);
        wr(A_CMD, 32'h1);
        u_host.set(500000, 0, 0);
        vchg(d); chk("no limits", 32'd500000, d);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_force();
        t_vel_estop();
        t_stops();
        t_warn();
        t_fault();
        t_bypass();
        report_and_stop();
    end
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
